//--- rtl/srpc_defs.svh
// Offsets, reset values, field positions and timing counts for supply control
`ifndef SRPC_DEFS_SVH
`define SRPC_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define SRPC_ADDR_W          5
`define SRPC_ADDR_CHIP_STATE 5'h00
`define SRPC_ADDR_TRIM       5'h0B
`define SRPC_CHIP_STATE_RST  8'h01
`define SRPC_TRIM_RST        8'h87

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SRPC_CS_SUPPLY_5V    0
`define SRPC_CS_RX_ONLY      1
`define SRPC_CS_RF_ALL       5
`define SRPC_CS_STANDBY      7
`define SRPC_TR_AUTO         7

// ----------------------------------------------------------------------
// Rail levels in 10 mV units
// ----------------------------------------------------------------------
`define SRPC_HEAD_250        10'h019
`define SRPC_HEAD_350        10'h023
`define SRPC_HEAD_400        10'h028
`define SRPC_RF_CAP          10'h1F4
`define SRPC_AX_CAP          10'h154
`define SRPC_RF_MAN_BASE     10'h1AE
`define SRPC_LOW_MAN_BASE    10'h10E
`define SRPC_STEP            10'h00A

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SRPC_CLK_NS          40
`define SRPC_SETTLE_NS       20000
`define SRPC_SETTLE_CYC      (`SRPC_SETTLE_NS / `SRPC_CLK_NS)

`endif

//--- rtl/srpc_pkg.sv
// Types shared by the supply regulator power control block
package srpc_pkg;

   // ----------------------------------------------------------------------
   // Rail set in 10 mV units
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [9:0] rf_amp_rail;
      logic [9:0] analog_rail;
      logic [9:0] digital_rail;
   } srpc_rail_set_type;

   // ----------------------------------------------------------------------
   // Regulator sequencing state
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      SRPC_OFF    = 3'b001,
      SRPC_SETTLE = 3'b010,
      SRPC_READY  = 3'b100
   } srpc_state_type;

endpackage : srpc_pkg

//--- rtl/srpc_rise.sv
// Rising edge detector with a selectable history value after reset
`timescale 1ns/1ns
module srpc_rise #(
   parameter logic INIT = 1'b0
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Level in, pulse out
   input  wire logic level_i,
   output logic      rise_o
);

   logic prev_q;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         prev_q <= INIT;
      end else begin
         prev_q <= level_i;
      end
   end

   assign rise_o = level_i & ~prev_q;

endmodule : srpc_rise

//--- rtl/srpc_top.sv
// Supply regulator trim and power enable control with host registers
//
// Function
// - Chip state bit 0 picks 5-V or 3-V supply and its trim table.
// - After reset the supply selection indicates the 5-V configuration.
// - Trim bit 7 one selects automatic trim, zero manual; automatic default.
// - Automatic headroom by bits 1:0: 11 250 mV, 10 350, 00 400 mV.
// - Manual 5-V: code sets RF rail 4.3 to 5 V; others 3.4 V.
// - Manual 3-V: code sets all rails 2.7 to 3.4 V together.
// - Automatic default 250 mV below supply, RF capped 5 V, others 3.4 V.
// - Power state follows primary pin, wake pin and chip state bits.
// - Primary enable high runs regulators, oscillator and host clock.
// - Automatic trim starts on enable rise or trim bit 7 rising while enable is high.
// - Chip state bit 7 standby, bit 5 whole RF, bit 1 receiver.
`timescale 1ns/1ns
`include "srpc_defs.svh"
module srpc_top (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rstn_i,
   // Host register port
   input  wire logic [`SRPC_ADDR_W-1:0]    reg_addr_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   input  wire logic [7:0]                 reg_wdata_i,
   output logic [7:0]                      reg_rdata_o,
   // Enable pins and supply level in 10 mV units
   input  wire logic                       en_i,
   input  wire logic                       secondary_wake_pin_i,
   input  wire logic [9:0]                 main_supply_input_i,
   // Power enables
   output logic                            regulators_en_o,
   output logic                            osc_run_o,
   output logic                            host_clock_output_en_o,
   output logic                            aux_clock_en_o,
   output logic                            digital_rail_en_o,
   output logic                            standby_o,
   output logic                            rf_section_en_o,
   output logic                            rx_en_o,
   // Regulator trim
   output logic                            supply_3v_mode_o,
   output logic                            auto_busy_o,
   output srpc_pkg::srpc_rail_set_type     rails_o
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [7:0]                  chip_state_q;
   logic [7:0]                  trim_q;
   logic [7:0]                  rdata_q;
   logic                        en_rise;
   logic                        auto_rise;
   logic                        auto_start;
   logic [9:0]                  head;
   logic [9:0]                  drop;
   logic [9:0]                  man_step;
   logic [9:0]                  settle_cnt_q;
   srpc_pkg::srpc_rail_set_type auto_rails;
   srpc_pkg::srpc_rail_set_type man_rails;
   srpc_pkg::srpc_rail_set_type rails_q;
   srpc_pkg::srpc_state_type    state_q;

   // ----------------------------------------------------------------------
   // Host registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         chip_state_q <= `SRPC_CHIP_STATE_RST;
         trim_q       <= `SRPC_TRIM_RST;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `SRPC_ADDR_CHIP_STATE) begin
            chip_state_q <= reg_wdata_i;
         end else if (reg_addr_i == `SRPC_ADDR_TRIM) begin
            trim_q <= reg_wdata_i;
         end
      end
   end

   // Unmapped addresses read as zero
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_i) begin
         if (reg_addr_i == `SRPC_ADDR_CHIP_STATE) begin
            rdata_q <= chip_state_q;
         end else if (reg_addr_i == `SRPC_ADDR_TRIM) begin
            rdata_q <= trim_q;
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   assign reg_rdata_o = rdata_q;

   // ----------------------------------------------------------------------
   // Start triggers
   // ----------------------------------------------------------------------
   srpc_rise #(
      .INIT (1'b0)
   ) u_en_rise (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .level_i (en_i),
      .rise_o  (en_rise)
   );

   // History starts at one so the reset default alone is no trigger
   srpc_rise #(
      .INIT (1'b1)
   ) u_auto_rise (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .level_i (trim_q[`SRPC_TR_AUTO]),
      .rise_o  (auto_rise)
   );

   // Bit 7 must go 1-0-1 to rerun; a plain rewrite of 1 does nothing
   assign auto_start = en_i & trim_q[`SRPC_TR_AUTO]
                     & (en_rise | auto_rise);

   // ----------------------------------------------------------------------
   // Rail targets
   // ----------------------------------------------------------------------
   always_comb begin
      // Code 01 is not defined; it falls to the widest headroom
      if (trim_q[1:0] == 2'b11) begin
         head = `SRPC_HEAD_250;
      end else if (trim_q[1:0] == 2'b10) begin
         head = `SRPC_HEAD_350;
      end else begin
         head = `SRPC_HEAD_400;
      end
      drop = (main_supply_input_i > head)
           ? 10'(main_supply_input_i - head) : 10'h000;
      auto_rails.rf_amp_rail  = (drop > `SRPC_RF_CAP) ? `SRPC_RF_CAP
                                                       : drop;
      auto_rails.analog_rail  = (drop > `SRPC_AX_CAP) ? `SRPC_AX_CAP
                                                       : drop;
      auto_rails.digital_rail = auto_rails.analog_rail;
   end

   always_comb begin
      man_step = 10'(10'(trim_q[2:0]) * `SRPC_STEP);
      if (chip_state_q[`SRPC_CS_SUPPLY_5V]) begin
         man_rails.rf_amp_rail  = 10'(`SRPC_RF_MAN_BASE + man_step);
         man_rails.analog_rail  = `SRPC_AX_CAP;
         man_rails.digital_rail = `SRPC_AX_CAP;
      end else begin
         man_rails.rf_amp_rail  = 10'(`SRPC_LOW_MAN_BASE + man_step);
         man_rails.analog_rail  = man_rails.rf_amp_rail;
         man_rails.digital_rail = man_rails.rf_amp_rail;
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state_q      <= srpc_pkg::SRPC_OFF;
         settle_cnt_q <= 10'h000;
      end else if (!en_i) begin
         state_q      <= srpc_pkg::SRPC_OFF;
         settle_cnt_q <= 10'h000;
      end else if (auto_start) begin
         state_q      <= srpc_pkg::SRPC_SETTLE;
         settle_cnt_q <= 10'h000;
      end else begin
         case (state_q)
            srpc_pkg::SRPC_OFF: begin
               state_q <= srpc_pkg::SRPC_READY;
            end
            srpc_pkg::SRPC_SETTLE: begin
               if (settle_cnt_q == 10'(`SRPC_SETTLE_CYC - 1)) begin
                  state_q <= srpc_pkg::SRPC_READY;
               end
               settle_cnt_q <= 10'(settle_cnt_q + 10'h001);
            end
            default: begin
               state_q <= srpc_pkg::SRPC_READY;
            end
         endcase
      end
   end

   // Automatic targets are sampled once per start, not tracked
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rails_q <= '0;
      end else if (!trim_q[`SRPC_TR_AUTO]) begin
         rails_q <= man_rails;
      end else if (auto_start) begin
         rails_q <= auto_rails;
      end
   end

   // ----------------------------------------------------------------------
   // Power enables
   // ----------------------------------------------------------------------
   assign regulators_en_o        = en_i;
   assign osc_run_o              = en_i;
   assign host_clock_output_en_o = en_i;
   assign aux_clock_en_o         = ~en_i & secondary_wake_pin_i;
   assign digital_rail_en_o      = en_i | secondary_wake_pin_i;
   assign standby_o       = en_i & chip_state_q[`SRPC_CS_STANDBY];
   assign rf_section_en_o = en_i & ~standby_o
                          & chip_state_q[`SRPC_CS_RF_ALL];
   assign rx_en_o         = en_i & ~standby_o
                          & (chip_state_q[`SRPC_CS_RF_ALL]
                          | chip_state_q[`SRPC_CS_RX_ONLY]);
   assign supply_3v_mode_o = ~chip_state_q[`SRPC_CS_SUPPLY_5V];
   assign auto_busy_o      = (state_q == srpc_pkg::SRPC_SETTLE);
   assign rails_o          = rails_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence s_auto_set_write;
      en_i && reg_wr_i && reg_addr_i == `SRPC_ADDR_TRIM
      && reg_wdata_i[7] && !trim_q[7];
   endsequence

   sequence s_trim_write_read;
      (reg_wr_i && reg_addr_i == `SRPC_ADDR_TRIM) ##1
      (reg_rd_i && !reg_wr_i && reg_addr_i == `SRPC_ADDR_TRIM);
   endsequence

   property p_reset_5v;
      @(posedge clk_i) $rose(rstn_i) |-> !supply_3v_mode_o;
   endproperty
   a_reset_5v: assert property (p_reset_5v)
      else $error("supply mode not 5-V after reset");

   property p_mode_write;
      @(posedge clk_i) disable iff (!rstn_i)
      reg_wr_i && reg_addr_i == `SRPC_ADDR_CHIP_STATE
      |=> supply_3v_mode_o == !$past(reg_wdata_i[0]);
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("supply mode does not follow chip state bit 0");

   // Dropping the enable legally ends the settle early
   property p_en_start;
      @(posedge clk_i) disable iff (!rstn_i || !en_i)
      en_rise && trim_q[7] |=> auto_busy_o [*8];
   endproperty
   a_en_start: assert property (p_en_start)
      else $error("automatic trim not started by enable rise");

   property p_bit_start;
      @(posedge clk_i) disable iff (!rstn_i)
      s_auto_set_write ##1 en_i |=> auto_busy_o;
   endproperty
   a_bit_start: assert property (p_bit_start)
      else $error("automatic trim not started by bit 7 rise");

   property p_auto_250;
      @(posedge clk_i) disable iff (!rstn_i)
      auto_start && trim_q[1:0] == 2'b11 && main_supply_input_i == 10'h1C2
      |=> rails_o.rf_amp_rail == 10'h1A9
          && rails_o.analog_rail == `SRPC_AX_CAP;
   endproperty
   a_auto_250: assert property (p_auto_250)
      else $error("automatic rails wrong for 250 mV headroom");

   property p_man_5v;
      @(posedge clk_i) disable iff (!rstn_i)
      !trim_q[7] && chip_state_q[0]
      |=> rails_o.rf_amp_rail == 10'(`SRPC_RF_MAN_BASE
          + 10'($past(trim_q[2:0])) * `SRPC_STEP)
          && rails_o.digital_rail == `SRPC_AX_CAP;
   endproperty
   a_man_5v: assert property (p_man_5v)
      else $error("manual 5-V rails wrong");

   property p_man_3v;
      @(posedge clk_i) disable iff (!rstn_i)
      !trim_q[7] && !chip_state_q[0]
      |=> rails_o.rf_amp_rail == 10'(`SRPC_LOW_MAN_BASE
          + 10'($past(trim_q[2:0])) * `SRPC_STEP)
          && rails_o.analog_rail == rails_o.rf_amp_rail
          && rails_o.digital_rail == rails_o.rf_amp_rail;
   endproperty
   a_man_3v: assert property (p_man_3v)
      else $error("manual 3-V rails wrong");

   property p_en_drop;
      @(posedge clk_i) disable iff (!rstn_i)
      $fell(en_i) |-> !regulators_en_o && !osc_run_o ##1 !auto_busy_o;
   endproperty
   a_en_drop: assert property (p_en_drop)
      else $error("power not removed after enable falls");

   property p_standby;
      @(posedge clk_i) disable iff (!rstn_i)
      en_i && chip_state_q[7] |-> standby_o && !rf_section_en_o && !rx_en_o;
   endproperty
   a_standby: assert property (p_standby)
      else $error("RF active in standby");

   property p_readback;
      @(posedge clk_i) disable iff (!rstn_i)
      s_trim_write_read |=> reg_rdata_o == $past(reg_wdata_i, 2);
   endproperty
   a_readback: assert property (p_readback)
      else $error("trim register readback differs from write");

endmodule : srpc_top

//--- testbench/srpc_host_model.sv
// Host controller model driving enable pins and the register port
`timescale 1ns/1ns
`include "srpc_defs.svh"
module srpc_host_model (
   // Clock
   input  wire logic                    clk_i,
   // Register port
   output logic [`SRPC_ADDR_W-1:0]      reg_addr_o,
   output logic                         reg_wr_o,
   output logic                         reg_rd_o,
   output logic [7:0]                   reg_wdata_o,
   // Pins and supply level
   output logic                         en_o,
   output logic                         secondary_wake_pin_o,
   output logic [9:0]                   main_supply_input_o
);
   initial begin
      reg_addr_o           = 5'h1F;
      reg_wr_o             = 1'b0;
      reg_rd_o             = 1'b0;
      reg_wdata_o          = 8'h00;
      en_o                 = 1'b0;
      secondary_wake_pin_o = 1'b0;
      main_supply_input_o  = 10'h1C2;
   end

   // -------------------------------------------------------------------
   // Bus cycles
   // -------------------------------------------------------------------
   // Released lines flip so stale data is never mistaken for a request
   task write_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      reg_wr_o    <= 1'b1;
      @(posedge clk_i);
      reg_wr_o    <= 1'b0;
      reg_wdata_o <= ~d;
      reg_addr_o  <= ~a;
   endtask : write_reg

   task read_reg(input logic [4:0] a);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge clk_i);
      reg_rd_o   <= 1'b0;
      reg_addr_o <= ~a;
   endtask : read_reg

   // Write then read the same address on back-to-back edges
   task write_read(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      reg_wr_o    <= 1'b1;
      @(posedge clk_i);
      reg_wr_o    <= 1'b0;
      reg_rd_o    <= 1'b1;
      @(posedge clk_i);
      reg_rd_o    <= 1'b0;
      reg_wdata_o <= ~d;
      reg_addr_o  <= ~a;
   endtask : write_read

   // Enable, wake pin and supply level are driven together on the next edge
   task set_pins(input logic e, input logic w, input logic [9:0] s);
      @(posedge clk_i);
      en_o                 <= e;
      secondary_wake_pin_o <= w;
      main_supply_input_o  <= s;
   endtask : set_pins
endmodule : srpc_host_model

//--- testbench/srpc_top_test.sv
// Self-checking bench for the supply regulator power control block
`timescale 1ns/1ns
`include "srpc_defs.svh"
module srpc_top_test;
   logic                        clk_i;
   logic                        rstn_i;
   wire logic [4:0]             addr;
   wire logic                   wr;
   wire logic                   rd;
   wire logic [7:0]             wdata;
   wire logic                   en;
   wire logic                   wake;
   wire logic [9:0]             sup;
   logic [7:0]                  rdata;
   wire logic [7:0]             pwr;
   logic                        mode3v;
   logic                        busy;
   srpc_pkg::srpc_rail_set_type rails;
   int                          fail_count;
   int                          num_checks;
   int                          cyc;
   logic [31:0]                 lfsr;
   logic [7:0]                  exp_q[$];
   logic [9:0]                  sups[6]  = '{10'd450, 10'd450, 10'd450,
                                             10'd560, 10'd300, 10'd450};
   logic [1:0]                  codes[6] = '{2'b11, 2'b10, 2'b00, 2'b11,
                                             2'b11, 2'b01};
   logic [9:0]                  dlt[6]   = '{10'd25, 10'd35, 10'd40,
                                             10'd25, 10'd25, 10'd40};
   logic [7:0]                  css[8]   = '{8'h21, 8'h31, 8'h03, 8'h01,
                                             8'h81, 8'hA3, 8'h00, 8'h82};

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   srpc_host_model i_host (.clk_i(clk_i), .reg_addr_o(addr),
      .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata), .en_o(en),
      .secondary_wake_pin_o(wake), .main_supply_input_o(sup));

   srpc_top i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .en_i(en), .secondary_wake_pin_i(wake),
      .main_supply_input_i(sup), .regulators_en_o(pwr[7]),
      .osc_run_o(pwr[6]), .host_clock_output_en_o(pwr[5]),
      .aux_clock_en_o(pwr[4]), .digital_rail_en_o(pwr[3]),
      .standby_o(pwr[2]), .rf_section_en_o(pwr[1]), .rx_en_o(pwr[0]),
      .supply_3v_mode_o(mode3v), .auto_busy_o(busy), .rails_o(rails));

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   task wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_cyc

   task rd_chk(input logic [4:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      i_host.read_reg(a);
   endtask : rd_chk

   task wr_rd_chk(input logic [4:0] a, input logic [7:0] d);
      exp_q.push_back(d);
      i_host.write_read(a, d);
   endtask : wr_rd_chk

   task start_auto(input logic [1:0] hc);
      lfsr = lfsr_next(lfsr);
      i_host.write_reg(`SRPC_ADDR_TRIM, 8'h00);
      i_host.write_reg(`SRPC_ADDR_TRIM, {1'b1, lfsr[6:2], hc});
      wait_cyc(3);
   endtask : start_auto

   // Read data is checked 1 ns after the edge that takes the strobe
   always @(posedge clk_i) begin
      if (rd === 1'b1) begin
         #1;
         if (exp_q.size() == 0)
            chk(32'h0, 32'h1);
         else
            chk(rdata, exp_q.pop_front());
      end
   end

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin : main_seq
      logic [7:0] v;
      logic [9:0] rf;
      logic [9:0] ax;
      rstn_i = 1'b0;
      fail_count = 0;
      num_checks = 0;
      lfsr = 32'h91D7;
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      wait_cyc(1);
      rd_chk(`SRPC_ADDR_CHIP_STATE, `SRPC_CHIP_STATE_RST);
      rd_chk(`SRPC_ADDR_TRIM, 8'h87);
      chk(mode3v, 1'b0);
      $display("done: reset values");
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         v = lfsr[15:8];
         wr_rd_chk(`SRPC_ADDR_TRIM, lfsr[7:0]);
         i_host.write_reg(`SRPC_ADDR_CHIP_STATE, v);
         rd_chk(`SRPC_ADDR_CHIP_STATE, v);
         chk(mode3v, !v[0]);
      end
      i_host.write_reg(5'h03, 8'h5A);
      rd_chk(5'h03, 8'h00);
      rd_chk(`SRPC_ADDR_CHIP_STATE, v);
      $display("done: register access");
      for (int i = 0; i < 32; i++) begin
         if (i % 4 == 0)
            i_host.write_reg(`SRPC_ADDR_CHIP_STATE, css[i / 4]);
         i_host.set_pins(i[0], i[1], 10'd450);
         wait_cyc(1);
         chk(pwr, {en, en, en, !en & wake, en | wake, en & css[i / 4][7],
            en & !css[i / 4][7] & css[i / 4][5],
            en & !css[i / 4][7] & (css[i / 4][5] | css[i / 4][1])});
      end
      $display("done: power enables");
      for (int m = 0; m < 2; m++) begin
         i_host.write_reg(`SRPC_ADDR_CHIP_STATE, (m == 1) ? 8'h00 : 8'h01);
         for (int c = 0; c < 8; c++) begin
            lfsr = lfsr_next(lfsr);
            i_host.write_reg(`SRPC_ADDR_TRIM, {1'b0, lfsr[3:0], c[2:0]});
            wait_cyc(2);
            rf = (m == 1) ? 10'd270 + 10'd10 * c : 10'd430 + 10'd10 * c;
            ax = (m == 1) ? rf : 10'd340;
            chk(rails, {rf, ax, ax});
         end
      end
      $display("done: manual trim");
      for (int k = 0; k < 6; k++) begin
         if (k == 4)
            i_host.write_reg(`SRPC_ADDR_CHIP_STATE, 8'h00);
         i_host.set_pins(1'b1, 1'b0, sups[k]);
         start_auto(codes[k]);
         rf = sups[k] - dlt[k];
         ax = (rf > 10'd340) ? 10'd340 : rf;
         rf = (rf > 10'd500) ? 10'd500 : rf;
         chk(busy, 1'b1);
         chk(rails, {rf, ax, ax});
      end
      wait_cyc(490);
      chk(busy, 1'b1);
      wait_cyc(15);
      chk(busy, 1'b0);
      i_host.write_reg(`SRPC_ADDR_TRIM, 8'h87);
      wait_cyc(3);
      chk(busy, 1'b0);
      i_host.set_pins(1'b0, 1'b0, 10'd450);
      wait_cyc(2);
      i_host.set_pins(1'b1, 1'b0, 10'd450);
      wait_cyc(3);
      chk(busy, 1'b1);
      chk(rails, {10'd425, 10'd340, 10'd340});
      wait_cyc(8);
      i_host.set_pins(1'b0, 1'b0, 10'd450);
      start_auto(2'b11);
      chk(busy, 1'b0);
      $display("done: automatic trim");
      tally_and_finish();
   end : main_seq
endmodule : srpc_top_test
